// File: trace_message_encoder.sv
// Trace message encoder: turns trace requests into packetised port words
//
// Behaviour
// RULE1: Every message opens with the six-bit transfer code, then its packets in order.
// RULE2: Variable packets drop leading zeroes but always end on a port word.
// RULE3: Fixed packets are always sent at full width.
// RULE4: All listed message kinds leave through the auxiliary output port.
// RULE5: The tool writes debug registers over JTAG, never over this port.
// RULE6: Direct branch uses code 3 and one eight-bit instruction count.
// RULE7: Indirect branch uses code 4: event id, count, relative address.
// RULE8: Direct branch with sync uses code 11: count, absolute address.
// RULE9: Indirect branch with sync uses code 12: event id, count, absolute address.
// RULE10: Branch with target uses code 57: count, relative address.
// RULE11: Program sync uses code 9: count and full program counter.
// RULE12: Resource full uses code 27: four-bit kind, eight-bit data.
// RULE13: Correlation uses code 33: four-bit event, eight-bit count.
// RULE14: Data write and read use codes 5 and 6: size, address, data.
// RULE15: Synced data write and read use codes 13 and 14.
// RULE16: Read-modify-write uses code 58: kind, bit index, relative address.
// RULE17: Synced read-modify-write uses code 59: kind, bit index, absolute address.
// RULE18: Trace watchpoint hit uses code 56 and a two-bit fired mask.
// RULE19: Code 63 is never sent.
// RULE20: Unassigned codes are never sent; such requests are refused.
`timescale 1ns/1ps
module trace_message_encoder #(
  parameter int PORT_W = 4
) (
  // Clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      reset,
  input  wire logic                      ce,
  // Trace request
  input  wire logic                      req_valid,
  input  wire trace_msg_pkg::trace_req_s req,
  output logic                           req_ready,
  output logic                           bad_code,
  // Auxiliary output port
  output logic                           trace_valid,
  output logic [PORT_W-1:0]              trace_data,
  output logic                           pkt_end,
  output logic                           msg_end
);
  import trace_msg_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Build one packet descriptor
  function automatic field_s slot(logic [31:0] v, logic [5:0] w, logic vl);
    field_s s;
    s.val = v;
    s.width = w;
    s.varlen = vl;
    return s;
  endfunction

  // Port words needed for a packet; variable ones shed leading zeroes
  function automatic logic [5:0] field_words(field_s f);
    logic [5:0] bits;
    bits = f.width;                                             // RULE3
    if (f.varlen) begin
      bits = 6'h01;
      for (int i = 0; i < 32; i++) begin
        if (f.val[i]) begin
          bits = 6'(i + 1);                                     // RULE2
        end
      end
    end
    return 6'((int'(bits) + PORT_W - 1) / PORT_W);              // RULE2
  endfunction

  // Packet layout per message kind; count of zero marks a refused code
  function automatic msg_plan_s plan_msg(trace_req_s r);
    msg_plan_s p;
    logic [31:0] icnt;
    p = '0;
    icnt = {24'h0, r.instr_count};
    p.f[0] = slot({26'h0, r.code}, W_TCODE, 1'b0);              // RULE1
    unique case (r.code)
      DIRECT_BRANCH_MSG: begin                                  // RULE6
        p.count = 3'h2;
        p.f[1] = slot(icnt, W_ICNT, 1'b1);
      end
      INDIRECT_BRANCH_MSG, INDIRECT_BRANCH_SYNC_MSG: begin      // RULE7 RULE9
        p.count = 3'h4;
        p.f[1] = slot({30'h0, r.event_ident}, W_EVT, 1'b0);
        p.f[2] = slot(icnt, W_ICNT, 1'b1);
        p.f[3] = slot(r.address, W_ADDR, 1'b1);
      end
      TRACE_SYNC_MSG, DIRECT_BRANCH_SYNC_MSG, BRANCH_TARGET_MSG: begin  // RULE8 RULE10 RULE11
        p.count = 3'h3;
        p.f[1] = slot(icnt, W_ICNT, 1'b1);
        p.f[2] = slot(r.address, W_ADDR, 1'b1);
      end
      RESOURCE_FULL_MSG: begin                                  // RULE12
        p.count = 3'h3;
        p.f[1] = slot({28'h0, r.resource_kind}, W_RKIND, 1'b0);
        p.f[2] = slot({24'h0, r.resource_data}, W_RDATA, 1'b1);
      end
      CORRELATION_MSG: begin                                    // RULE13
        p.count = 3'h3;
        p.f[1] = slot({28'h0, r.correlation_event}, W_CEVENT, 1'b0);
        p.f[2] = slot(icnt, W_ICNT, 1'b1);
      end
      DATA_WRITE_MSG, DATA_READ_MSG,
      DATA_WRITE_SYNC_MSG, DATA_READ_SYNC_MSG: begin            // RULE14 RULE15
        p.count = 3'h4;
        p.f[1] = slot({30'h0, r.access_size}, W_SIZE, 1'b0);
        p.f[2] = slot(r.address, W_ADDR, 1'b1);
        p.f[3] = slot(r.data, W_DATA, 1'b1);
      end
      RMW_TRACE_MSG, RMW_TRACE_SYNC_MSG: begin                  // RULE16 RULE17
        p.count = 3'h4;
        p.f[1] = slot({30'h0, r.rmw_kind}, W_RMW, 1'b0);
        p.f[2] = slot({27'h0, r.bit_index}, W_BIT, 1'b0);
        p.f[3] = slot(r.address, W_ADDR, 1'b1);
      end
      TRACE_WATCH_HIT_MSG: begin                                // RULE18
        p.count = 3'h2;
        p.f[1] = slot({30'h0, r.watch_fired_mask}, W_WMASK, 1'b0);
      end
      default: begin                                            // RULE19 RULE20
        p.count = FIELD_CNT_RST;
      end
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Serialiser state
  // ----------------------------------------------------------------
  logic        busy;
  logic        next_busy;
  msg_plan_s   plan;
  msg_plan_s   next_plan;
  logic [1:0]  field;
  logic [1:0]  next_field;
  logic [31:0] shift;
  logic [31:0] next_shift;
  logic [5:0]  words_left;
  logic [5:0]  next_words_left;
  logic        next_bad_code;

  // Next-state: accept, shift out words, step through packets
  always_comb begin
    msg_plan_s  p;
    logic [1:0] nf;
    p = plan_msg(req);
    nf = field + 2'h1;
    next_busy = busy;
    next_plan = plan;
    next_field = field;
    next_shift = shift;
    next_words_left = words_left;
    next_bad_code = 1'b0;
    if (busy) begin
      if (words_left == 6'h01) begin
        if ({1'b0, field} == plan.count - 3'h1) begin
          next_busy = 1'b0;
        end else begin
          next_field = nf;                                      // RULE1
          next_shift = plan.f[nf].val;
          next_words_left = field_words(plan.f[nf]);
        end
      end else begin
        next_shift = shift >> PORT_W;
        next_words_left = words_left - 6'h01;
      end
    end else if (req_valid) begin
      if (p.count == FIELD_CNT_RST) begin
        next_bad_code = 1'b1;                                   // RULE20
      end else begin
        next_busy = 1'b1;                                       // RULE4
        next_plan = p;
        next_field = 2'h0;
        next_shift = p.f[0].val;
        next_words_left = field_words(p.f[0]);
      end
    end
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      plan <= '0;
      field <= 2'h0;
      shift <= 32'h0;
      words_left <= WORDS_RST;
      bad_code <= 1'b0;
    end else if (ce) begin
      busy <= next_busy;
      plan <= next_plan;
      field <= next_field;
      shift <= next_shift;
      words_left <= next_words_left;
      bad_code <= next_bad_code;
    end
  end

  // Port outputs
  assign req_ready = !busy;
  assign trace_valid = busy;
  assign trace_data = shift[PORT_W-1:0];
  assign pkt_end = busy && (words_left == 6'h01);               // RULE2
  assign msg_end = pkt_end && ({1'b0, field} == plan.count - 3'h1);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_refuse_unknown: assert property (@(posedge ref_clk) disable iff (reset) // RULE20
    ce && !busy && req_valid && plan_msg(req).count == 3'h0 |=> bad_code && !busy)
    else $error("unassigned code was not refused");
  a_no_extension: assert property (@(posedge ref_clk) disable iff (reset) // RULE19
    busy |-> plan.f[0].val[5:0] != EXTENSION_CODE)
    else $error("reserved extension code sent");
  a_code_first: assert property (@(posedge ref_clk) disable iff (reset) // RULE1
    $rose(busy) |-> field == 2'h0 && shift[5:0] == plan.f[0].val[5:0] && !plan.f[0].varlen)
    else $error("message does not open with its code");
  a_fixed_width: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
    busy && !plan.f[field].varlen && ($rose(busy) || $changed(field))
      |-> int'(words_left) == (int'(plan.f[field].width) + PORT_W - 1) / PORT_W)
    else $error("fixed packet truncated");
  a_packet_close: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
    ce && pkt_end && !msg_end |=> busy && (field == $past(field) + 2'h1))
    else $error("packet did not end on a port word");
  a_msg_close: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
    ce && msg_end |=> !busy && req_ready)
    else $error("message did not close");
  a_direct_branch: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
    busy && plan.f[0].val[5:0] == 6'h03 |-> plan.count == 3'h2 && plan.f[1].width == W_ICNT)
    else $error("direct branch layout wrong");
  a_indirect_branch: assert property (@(posedge ref_clk) disable iff (reset) // RULE7
    busy && plan.f[0].val[5:0] == 6'h04 |-> plan.count == 3'h4
      && plan.f[1].width == W_EVT && plan.f[2].width == W_ICNT && plan.f[3].width == W_ADDR)
    else $error("indirect branch layout wrong");
  a_data_trace: assert property (@(posedge ref_clk) disable iff (reset) // RULE14
    busy && (plan.f[0].val[5:0] == 6'h05 || plan.f[0].val[5:0] == 6'h06) |-> plan.count == 3'h4
      && plan.f[1].width == W_SIZE && plan.f[3].width == W_DATA)
    else $error("data trace layout wrong");
  a_rmw_trace: assert property (@(posedge ref_clk) disable iff (reset) // RULE16
    busy && plan.f[0].val[5:0] == 6'h3A |-> plan.f[2].width == W_BIT && !plan.f[2].varlen)
    else $error("read-modify-write layout wrong");

  // Layout of the synchronised and vendor program trace kinds
  a_direct_sync: assert property (@(posedge ref_clk) disable iff (reset) // RULE8
    busy && plan.f[0].val[5:0] == 6'h0B
      |-> plan.count == 3'h3 && plan.f[1].width == W_ICNT
      && plan.f[2].width == W_ADDR)
    else $error("direct branch with sync layout wrong");
  a_indirect_sync: assert property (@(posedge ref_clk) disable iff (reset) // RULE9
    busy && plan.f[0].val[5:0] == 6'h0C
      |-> plan.count == 3'h4 && plan.f[1].width == W_EVT
      && plan.f[2].width == W_ICNT && plan.f[3].width == W_ADDR)
    else $error("indirect branch with sync layout wrong");
  a_branch_target: assert property (@(posedge ref_clk) disable iff (reset) // RULE10
    busy && plan.f[0].val[5:0] == 6'h39
      |-> plan.count == 3'h3 && plan.f[1].width == W_ICNT
      && plan.f[2].width == W_ADDR)
    else $error("branch with target layout wrong");
  a_trace_sync: assert property (@(posedge ref_clk) disable iff (reset) // RULE11
    busy && plan.f[0].val[5:0] == 6'h09
      |-> plan.count == 3'h3 && plan.f[1].width == W_ICNT
      && plan.f[2].width == W_ADDR)
    else $error("program sync layout wrong");

  // Layout of the resource, correlation, data and watchpoint kinds
  a_resource_full: assert property (@(posedge ref_clk) disable iff (reset) // RULE12
    busy && plan.f[0].val[5:0] == 6'h1B
      |-> plan.count == 3'h3 && plan.f[1].width == W_RKIND
      && !plan.f[1].varlen && plan.f[2].width == W_RDATA)
    else $error("resource full layout wrong");
  a_correlation: assert property (@(posedge ref_clk) disable iff (reset) // RULE13
    busy && plan.f[0].val[5:0] == 6'h21
      |-> plan.count == 3'h3 && plan.f[1].width == W_CEVENT
      && !plan.f[1].varlen && plan.f[2].width == W_ICNT)
    else $error("correlation layout wrong");
  a_data_sync: assert property (@(posedge ref_clk) disable iff (reset) // RULE15
    busy && (plan.f[0].val[5:0] == 6'h0D || plan.f[0].val[5:0] == 6'h0E)
      |-> plan.count == 3'h4 && plan.f[1].width == W_SIZE
      && plan.f[2].width == W_ADDR && plan.f[3].width == W_DATA)
    else $error("synced data trace layout wrong");
  a_rmw_sync: assert property (@(posedge ref_clk) disable iff (reset) // RULE17
    busy && plan.f[0].val[5:0] == 6'h3B
      |-> plan.count == 3'h4 && plan.f[1].width == W_RMW
      && plan.f[2].width == W_BIT && plan.f[3].width == W_ADDR)
    else $error("synced read-modify-write layout wrong");
  a_watch_hit: assert property (@(posedge ref_clk) disable iff (reset) // RULE18
    busy && plan.f[0].val[5:0] == 6'h38
      |-> plan.count == 3'h2 && plan.f[1].width == W_WMASK
      && !plan.f[1].varlen)
    else $error("trace watchpoint hit layout wrong");

  // Port behaviour: refusals, trimming and freezing
  a_extension_refused: assert property (@(posedge ref_clk) disable iff (reset) // RULE19
    ce && !busy && req_valid && req.code == EXTENSION_CODE |=> bad_code && !trace_valid)
    else $error("extension code was not refused");
  a_refuse_pulse: assert property (@(posedge ref_clk) disable iff (reset) // RULE20
    ce && !req_valid |=> !bad_code)
    else $error("refusal pulse outlived its request");
  a_zero_trim: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
    pkt_end && plan.f[field].varlen && trace_data == '0 |-> plan.f[field].val == 32'h0)
    else $error("variable packet kept a leading zero word");
  a_frozen_port: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
    !ce |=> $stable(trace_data) && $stable(trace_valid) && $stable(pkt_end))
    else $error("port moved while the enable was low");
  a_plan_held: assert property (@(posedge ref_clk) disable iff (reset) // RULE1
    ce && busy |=> $stable(plan))
    else $error("packet plan changed inside a message");

endmodule

// File: trace_message_encoder_tb.sv
// Self-checking bench for the trace message encoder
`timescale 1ns/1ps
module trace_message_encoder_tb;
  import trace_msg_pkg::*;
  localparam int PW = 4;
  logic          ref_clk     = 1'b0;
  logic          reset       = 1'b1;
  logic          ce          = 1'b1;
  logic          req_valid   = 1'b0;
  trace_req_s    req         = '0;
  logic          req_ready;
  logic          bad_code;
  logic          trace_valid;
  logic          pkt_end;
  logic          msg_end;
  logic [PW-1:0] trace_data;
  logic [PW+1:0] exp_q[$];
  int            mismatches  = 0;
  int            checks_done = 0;

  trace_message_encoder #(.PORT_W(PW)) u_trace_message_encoder (
    .ref_clk(ref_clk), .reset(reset), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .bad_code(bad_code), .trace_valid(trace_valid),
    .trace_data(trace_data), .pkt_end(pkt_end), .msg_end(msg_end));
  trace_port_sink #(.PW(PW)) u_trace_port_sink (
    .ref_clk(ref_clk), .ce(ce), .trace_valid(trace_valid), .trace_data(trace_data),
    .pkt_end(pkt_end), .msg_end(msg_end));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Expected words of one packet; variable packets lose leading zero words
  task automatic add_pkt(input logic [31:0] v, input int w, input bit vl);
    int n;
    n = (w + PW - 1) / PW;
    if (vl) begin
      n = 1;
      for (int b = 0; b < w; b++) if (v[b]) n = b / PW + 1;
    end
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({((i == n - 1) ? 2'b01 : 2'b00), PW'(v >> (i * PW))});
    end
  endtask

  // Send one request, then compare every word and end flag seen by the tool
  task automatic run(input trace_req_s r);
    int n;
    int m0;
    exp_q.delete();
    u_trace_port_sink.words.delete();
    add_pkt(32'(r.code), 6, 1'b0);
    case (r.code)
      DIRECT_BRANCH_MSG: add_pkt(32'(r.instr_count), 8, 1'b1);
      TRACE_WATCH_HIT_MSG: add_pkt(32'(r.watch_fired_mask), 2, 1'b0);
      RESOURCE_FULL_MSG: begin
        add_pkt(32'(r.resource_kind), 4, 1'b0);
        add_pkt(32'(r.resource_data), 8, 1'b1);
      end
      CORRELATION_MSG: begin
        add_pkt(32'(r.correlation_event), 4, 1'b0);
        add_pkt(32'(r.instr_count), 8, 1'b1);
      end
      RMW_TRACE_MSG, RMW_TRACE_SYNC_MSG: begin
        add_pkt(32'(r.rmw_kind), 2, 1'b0);
        add_pkt(32'(r.bit_index), 5, 1'b0);
        add_pkt(r.address, 32, 1'b1);
      end
      DATA_WRITE_MSG, DATA_READ_MSG, DATA_WRITE_SYNC_MSG, DATA_READ_SYNC_MSG: begin
        add_pkt(32'(r.access_size), 2, 1'b0);
        add_pkt(r.address, 32, 1'b1);
        add_pkt(r.data, 32, 1'b1);
      end
      default: begin
        if (r.code inside {INDIRECT_BRANCH_MSG, INDIRECT_BRANCH_SYNC_MSG}) begin
          add_pkt(32'(r.event_ident), 2, 1'b0);
        end
        add_pkt(32'(r.instr_count), 8, 1'b1);
        add_pkt(r.address, 32, 1'b1);
      end
    endcase
    exp_q[exp_q.size() - 1][PW+1] = 1'b1;
    m0 = u_trace_port_sink.msgs;
    req <= r;
    req_valid <= 1'b1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    chk("busy ready", 0, req_ready);
    chk("busy valid", 1, trace_valid);
    for (n = 0; n < 100 && u_trace_port_sink.msgs == m0; n++) @(posedge ref_clk);
    chk("word count", exp_q.size(), u_trace_port_sink.words.size());
    foreach (exp_q[i]) begin
      if (i < u_trace_port_sink.words.size()) begin
        chk("port word", exp_q[i], u_trace_port_sink.words[i]);
      end
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_program();
    trace_req_s r;
    tcode_e     ks[4] = '{DIRECT_BRANCH_SYNC_MSG, INDIRECT_BRANCH_SYNC_MSG,
                          TRACE_SYNC_MSG, BRANCH_TARGET_MSG};
    r = '0;
    r.code = DIRECT_BRANCH_MSG;
    r.instr_count = 8'h05;
    fork
      begin
        repeat (2) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join_none
    run(r);
    r.code = INDIRECT_BRANCH_MSG;
    r.event_ident = 2'h2;
    r.instr_count = 8'hA7;
    r.address = 32'h0000_0120;
    run(r);
    r.instr_count = 8'h00;
    r.address = 32'hFFFF_FFFF;
    foreach (ks[i]) begin
      r.code = ks[i];
      run(r);
    end
  endtask

  task automatic t_data();
    trace_req_s r;
    tcode_e     ks[6] = '{DATA_WRITE_MSG, DATA_READ_MSG, DATA_WRITE_SYNC_MSG,
                          DATA_READ_SYNC_MSG, RMW_TRACE_MSG, RMW_TRACE_SYNC_MSG};
    r = '0;
    r.access_size = 2'h1;
    r.rmw_kind = 2'h1;
    r.bit_index = 5'h01;
    r.address = 32'h8000_0000;
    r.data = 32'h0000_3C00;
    foreach (ks[i]) begin
      r.code = ks[i];
      run(r);
    end
  endtask

  task automatic t_other();
    trace_req_s r;
    tcode_e     ks[3] = '{RESOURCE_FULL_MSG, CORRELATION_MSG, TRACE_WATCH_HIT_MSG};
    r = '0;
    r.resource_kind = 4'h1;
    r.resource_data = 8'h00;
    r.correlation_event = 4'hC;
    r.instr_count = 8'h10;
    r.watch_fired_mask = 2'h3;
    foreach (ks[i]) begin
      r.code = ks[i];
      run(r);
    end
  endtask

  task automatic t_refuse();
    logic [5:0] bad[8] = '{6'h00, 6'h01, 6'h02, 6'h07, 6'h08, 6'h0F, 6'h22, 6'h3F};
    u_trace_port_sink.words.delete();
    foreach (bad[i]) begin
      req.code <= tcode_e'(bad[i]);
      req_valid <= 1'b1;
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      chk("refused pulse", 1, bad_code);
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    chk("pulse width", 0, bad_code);
    chk("refused words", 0, u_trace_port_sink.words.size());
  endtask

  // ------------------------------------------------------------
  // Clock, sequence and watchdog
  // ------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Free-running reference clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset ready", 1, req_ready);
    chk("reset valid", 0, trace_valid);
    @(posedge ref_clk);
    reset <= 1'b0;
    t_program();
    t_data();
    t_other();
    t_refuse();
    close_out();
  end

  // Cut a hang short
  initial begin
    #100000;
    mismatches++;
    close_out();
  end
endmodule

// File: trace_msg_pkg.sv
// Shared codes, field widths and carrier types for the trace message encoder
package trace_msg_pkg;

  // ----------------------------------------------------------------
  // Transfer codes
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DIRECT_BRANCH_MSG        = 6'h03,
    INDIRECT_BRANCH_MSG      = 6'h04,
    DATA_WRITE_MSG           = 6'h05,
    DATA_READ_MSG            = 6'h06,
    TRACE_SYNC_MSG           = 6'h09,
    DIRECT_BRANCH_SYNC_MSG   = 6'h0B,
    INDIRECT_BRANCH_SYNC_MSG = 6'h0C,
    DATA_WRITE_SYNC_MSG      = 6'h0D,
    DATA_READ_SYNC_MSG       = 6'h0E,
    RESOURCE_FULL_MSG        = 6'h1B,
    CORRELATION_MSG          = 6'h21,
    TRACE_WATCH_HIT_MSG      = 6'h38,
    BRANCH_TARGET_MSG        = 6'h39,
    RMW_TRACE_MSG            = 6'h3A,
    RMW_TRACE_SYNC_MSG       = 6'h3B
  } tcode_e;

  localparam logic [5:0] EXTENSION_CODE = 6'h3F;   // Held back, never sent

  // ----------------------------------------------------------------
  // Packet widths
  // ----------------------------------------------------------------
  localparam logic [5:0] W_TCODE  = 6'h06;
  localparam logic [5:0] W_ICNT   = 6'h08;
  localparam logic [5:0] W_EVT    = 6'h02;
  localparam logic [5:0] W_ADDR   = 6'h20;
  localparam logic [5:0] W_DATA   = 6'h20;
  localparam logic [5:0] W_RKIND  = 6'h04;
  localparam logic [5:0] W_RDATA  = 6'h08;
  localparam logic [5:0] W_CEVENT = 6'h04;
  localparam logic [5:0] W_SIZE   = 6'h02;
  localparam logic [5:0] W_RMW    = 6'h02;
  localparam logic [5:0] W_BIT    = 6'h05;
  localparam logic [5:0] W_WMASK  = 6'h02;

  // Reset values
  localparam logic [2:0] FIELD_CNT_RST = 3'h0;
  localparam logic [5:0] WORDS_RST     = 6'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    tcode_e      code;
    logic [1:0]  event_ident;
    logic [1:0]  access_size;
    logic [1:0]  rmw_kind;
    logic [4:0]  bit_index;
    logic [7:0]  instr_count;
    logic [3:0]  resource_kind;
    logic [7:0]  resource_data;
    logic [3:0]  correlation_event;
    logic [1:0]  watch_fired_mask;
    logic [31:0] address;
    logic [31:0] data;
  } trace_req_s;

  typedef struct packed {
    logic [31:0] val;
    logic [5:0]  width;
    logic        varlen;
  } field_s;

  typedef struct packed {
    logic [2:0]      count;
    field_s [3:0]    f;
  } msg_plan_s;

endpackage

// File: trace_port_sink.sv
// Debug tool model that collects the words leaving the auxiliary output port
`timescale 1ns/1ps
module trace_port_sink #(
  parameter int PW = 4
) (
  // Clock and enable
  input  wire logic          ref_clk,
  input  wire logic          ce,
  // Auxiliary output port
  input  wire logic          trace_valid,
  input  wire logic [PW-1:0] trace_data,
  input  wire logic          pkt_end,
  input  wire logic          msg_end
);
  logic [PW+1:0] words[$];
  int            msgs = 0;

  // Listen only: registers are reached over the scan path, never over this port
  always @(posedge ref_clk) begin
    if (ce && trace_valid) begin
      words.push_back({msg_end, pkt_end, trace_data});
      if (msg_end) begin
        msgs <= msgs + 1;
      end
    end
  end
endmodule
